// file: logic/brt_timing.sv
// Rate generator, 16-bit divider and four clock selectors with APB access
`timescale 1ns/1ns
module brt_timing
#(
    parameter int DIV_WIDTH = 16
)
(
    input  wire logic                 pclk,
    input  wire logic                 presetn,
    input  wire logic                 psel,
    input  wire logic                 penable,
    input  wire logic                 pwrite,
    input  wire logic [7:0]           paddr,
    input  wire logic [31:0]          pwdata,
    output logic      [31:0]          prdata,
    output logic                      pready,
    output logic                      pslverr,
    input  wire logic                 oscillator_input,
    input  wire logic                 input_port_bit_two,
    input  wire logic [3:0]           ext_timing_in,
    input  wire logic                 rx_char_strobe,
    output brt_pkg::brt_clk_s         chan_clk,
    output logic                      divider_pin,
    output logic                      irq
);
    import brt_pkg::*;

    if (DIV_WIDTH != 16)
    begin : g_chk
        $error("DIV_WIDTH must be 16 to match two preset bytes");
    end

    // ------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------
    wire logic setup_ph = psel & ~penable;
    wire logic access   = psel & penable;
    wire logic wr_en    = access & pwrite;
    wire logic hit_ctrl = paddr == BRT_OFS_CTRL;
    wire logic hit_lo   = paddr == BRT_OFS_PRE_LO;
    wire logic hit_hi   = paddr == BRT_OFS_PRE_HI;
    wire logic hit_cmd  = paddr == BRT_OFS_CMD;
    wire logic hit_sel  = paddr == BRT_OFS_CLKSEL;
    wire logic hit_stat = paddr == BRT_OFS_STATUS;
    wire logic hit_isr  = paddr == BRT_OFS_ISR;
    wire logic hit_imr  = paddr == BRT_OFS_IMR;
    wire logic mapped   = hit_ctrl | hit_lo | hit_hi | hit_cmd
                        | hit_sel | hit_stat | hit_isr | hit_imr;

    assign pready  = 1'b1;
    assign pslverr = access & ~mapped;

    // ------------------------------------------------------------
    // Software registers
    // ------------------------------------------------------------
    logic [4:0]           ctrl_q;
    logic [7:0]           pre_lo_q;
    logic [7:0]           pre_hi_q;
    logic [4*BRT_SEL_W-1:0] sel_q;
    logic [BRT_EV_W-1:0]  isr_q;
    logic [BRT_EV_W-1:0]  imr_q;
    logic [31:0]          prdata_q;

    wire logic      ext_mode = ctrl_q[BRT_CTRL_EXT_BIT];
    wire brt_mode_e mode     = brt_mode_e'(ctrl_q[BRT_CTRL_MODE_LSB+:2]);
    wire logic      src_ext  = ctrl_q[BRT_CTRL_SRC_BIT];
    wire logic      pin_en   = ctrl_q[BRT_CTRL_PIN_BIT];

    wire logic cmd_start = wr_en & hit_cmd & pwdata[BRT_CMD_START_BIT];
    wire logic cmd_stop  = wr_en & hit_cmd & pwdata[BRT_CMD_STOP_BIT];

    wire logic [15:0] preset = {pre_hi_q, pre_lo_q};

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ctrl_q   <= BRT_CTRL_RESET;
            pre_lo_q <= BRT_PRESET_RESET[7:0];
            pre_hi_q <= BRT_PRESET_RESET[15:8];
            sel_q    <= {4{BRT_SEL_RESET}};
            imr_q    <= '0;
        end
        else if (wr_en)
        begin
            if (hit_ctrl)
                ctrl_q <= pwdata[4:0];
            if (hit_lo)
                pre_lo_q <= pwdata[7:0];
            if (hit_hi)
                pre_hi_q <= pwdata[7:0];
            if (hit_sel)
                for (int i = 0; i < 4; i++)
                    sel_q[i*BRT_SEL_W+:BRT_SEL_W] <=
                        pwdata[i*BRT_SEL_STRIDE+:BRT_SEL_W];
            if (hit_imr)
                imr_q <= pwdata[BRT_EV_W-1:0];
        end
    end

    // ------------------------------------------------------------
    // Input edges
    // ------------------------------------------------------------
    logic       osc_q;
    logic       ip2_q;
    logic [3:0] ext_q;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            // Port bit two and external pins idle high on their pull-ups: no false edge after reset; oscillator register resets low
            osc_q <= 1'b0;
            ip2_q <= 1'b1;
            ext_q <= 4'hF;
        end
        else
        begin
            osc_q <= oscillator_input;
            ip2_q <= input_port_bit_two;
            ext_q <= ext_timing_in;
        end
    end

    wire logic       osc_tick = oscillator_input & ~osc_q;
    wire logic       ip2_tick = input_port_bit_two & ~ip2_q;
    wire logic [3:0] ext_tick = ext_timing_in & ~ext_q;

    // ------------------------------------------------------------
    // Programmable divider
    // ------------------------------------------------------------
    logic [DIV_WIDTH-1:0] cnt_q;
    logic                 run_q;
    logic                 out_q;
    logic                 div_tick_q;

    wire logic div_src  = src_ext ? ip2_tick : osc_tick;
    wire logic terminal = cnt_q <= DIV_WIDTH'(1);
    wire logic step     = run_q & div_src;
    wire logic is_timer = mode != BRT_MODE_COUNTER
                        && mode != BRT_MODE_TIMEOUT;
    wire logic ev_tc    = step & terminal
                        & (is_timer ? out_q
                                    : mode == BRT_MODE_COUNTER);
    wire logic ev_tmo   = step & terminal & (mode == BRT_MODE_TIMEOUT);
    wire logic tmo_kick = run_q & rx_char_strobe
                        & (mode == BRT_MODE_TIMEOUT);

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cnt_q      <= '0;
            run_q      <= 1'b0;
            out_q      <= 1'b0;
            div_tick_q <= 1'b0;
        end
        else
        begin
            div_tick_q <= 1'b0;
            if (cmd_stop)
                run_q <= 1'b0;
            else if (cmd_start)
            begin
                cnt_q <= preset;
                run_q <= 1'b1;
                out_q <= 1'b1;
            end
            else if (tmo_kick)
                cnt_q <= preset;
            else if (step)
            begin
                if (!terminal)
                    cnt_q <= cnt_q - DIV_WIDTH'(1);
                else if (is_timer)
                begin
                    cnt_q      <= preset;
                    out_q      <= ~out_q;
                    div_tick_q <= ~out_q;
                end
                else
                begin
                    run_q <= 1'b0;
                    out_q <= 1'b0;
                end
            end
        end
    end

    assign divider_pin = out_q & pin_en;

    // ------------------------------------------------------------
    // Interrupt status, set wins over clear
    // ------------------------------------------------------------
    wire logic [BRT_EV_W-1:0] ev_set = {ev_tmo, ev_tc};
    wire logic [BRT_EV_W-1:0] w1c    = (wr_en & hit_isr)
                                     ? pwdata[BRT_EV_W-1:0] : '0;
    wire logic [BRT_EV_W-1:0] clr    = w1c | {BRT_EV_W{cmd_stop}};

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            isr_q <= '0;
        else
            isr_q <= (isr_q & ~clr) | ev_set;
    end

    assign irq = |(isr_q & imr_q);

    // ------------------------------------------------------------
    // Clock selectors and divide-by-sixteen
    // ------------------------------------------------------------
    logic [3:0] clk16_q;
    logic [3:0] bit_q;
    logic [3:0] mid_q;

    for (genvar g = 0; g < 4; g++)
    begin : g_sel
        logic [BRT_RATE_W-1:0] rate_q;
        logic [3:0]            sub_q;

        wire logic [5:0] code = sel_q[g*BRT_SEL_W+:BRT_SEL_W];
        wire logic [BRT_RATE_W-1:0] div =
            brt_rate_div(code, ext_mode);
        wire logic gen_hit = osc_tick && div != '0
                          && rate_q >= div - BRT_RATE_W'(1);
        wire logic tick16 = (code == BRT_SEL_DIVIDER) ? div_tick_q
                          : (code == BRT_SEL_EXTERN)  ? ext_tick[g]
                          : gen_hit;

        always_ff @(posedge pclk or negedge presetn)
        begin
            if (!presetn)
            begin
                rate_q     <= '0;
                sub_q      <= 4'h0;
                clk16_q[g] <= 1'b0;
                bit_q[g]   <= 1'b0;
                mid_q[g]   <= 1'b0;
            end
            else
            begin
                if (gen_hit || div == '0)
                    rate_q <= '0;
                else if (osc_tick)
                    rate_q <= rate_q + BRT_RATE_W'(1);
                if (tick16)
                    sub_q <= sub_q + 4'h1;
                clk16_q[g] <= tick16;
                bit_q[g]   <= tick16 && sub_q == 4'hF;
                mid_q[g]   <= tick16 && sub_q == 4'h7;
            end
        end
    end

    assign chan_clk.clk16    = clk16_q;
    assign chan_clk.bit_tick = bit_q;
    assign chan_clk.mid_tick = mid_q;

    // ------------------------------------------------------------
    // Read data, captured in the setup phase
    // ------------------------------------------------------------
    logic [31:0] rd_mux;

    always_comb
    begin
        rd_mux = 32'h0000_0000;
        if (hit_ctrl)
            rd_mux = {27'h0, ctrl_q};
        if (hit_lo)
            rd_mux = {24'h0, is_timer ? pre_lo_q : cnt_q[7:0]};
        if (hit_hi)
            rd_mux = {24'h0, is_timer ? pre_hi_q : cnt_q[15:8]};
        if (hit_sel)
            for (int i = 0; i < 4; i++)
                rd_mux[i*BRT_SEL_STRIDE+:BRT_SEL_W] =
                    sel_q[i*BRT_SEL_W+:BRT_SEL_W];
        if (hit_stat)
            rd_mux = {14'h0, out_q, run_q, cnt_q};
        if (hit_isr)
            rd_mux = {30'h0, isr_q};
        if (hit_imr)
            rd_mux = {30'h0, imr_q};
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            prdata_q <= 32'h0000_0000;
        else if (setup_ph && !pwrite)
            prdata_q <= rd_mux;
    end

    assign prdata = prdata_q;

endmodule

// file: logic/brt_pkg.sv
// Shared constants, register map and types for the rate/divider block
package brt_pkg;

    // Register byte offsets
    localparam logic [7:0] BRT_OFS_CTRL   = 8'h00;
    localparam logic [7:0] BRT_OFS_PRE_LO = 8'h04;
    localparam logic [7:0] BRT_OFS_PRE_HI = 8'h08;
    localparam logic [7:0] BRT_OFS_CMD    = 8'h0C;
    localparam logic [7:0] BRT_OFS_CLKSEL = 8'h10;
    localparam logic [7:0] BRT_OFS_STATUS = 8'h14;
    localparam logic [7:0] BRT_OFS_ISR    = 8'h18;
    localparam logic [7:0] BRT_OFS_IMR    = 8'h1C;

    // Control register fields
    localparam int BRT_CTRL_EXT_BIT  = 0;
    localparam int BRT_CTRL_MODE_LSB = 1;
    localparam int BRT_CTRL_SRC_BIT  = 3;
    localparam int BRT_CTRL_PIN_BIT  = 4;
    localparam logic [4:0] BRT_CTRL_RESET = 5'h00;

    // Command bits, status fields, event bits
    localparam int BRT_CMD_START_BIT = 0;
    localparam int BRT_CMD_STOP_BIT  = 1;
    localparam int BRT_STAT_RUN_BIT  = 16;
    localparam int BRT_STAT_OUT_BIT  = 17;
    localparam int BRT_EV_TC_BIT     = 0;
    localparam int BRT_EV_TMO_BIT    = 1;
    localparam int BRT_EV_W          = 2;

    // Clock selector codes: 0..26 standard, 27..30 extended
    localparam int         BRT_SEL_W       = 6;
    localparam int         BRT_SEL_STRIDE  = 8;
    localparam logic [5:0] BRT_SEL_STD_LAST = 6'h1A;
    localparam logic [5:0] BRT_SEL_DIVIDER = 6'h20;
    localparam logic [5:0] BRT_SEL_EXTERN  = 6'h21;
    localparam logic [5:0] BRT_SEL_RESET   = 6'h00;
    localparam logic [15:0] BRT_PRESET_RESET = 16'h0002;

    localparam int BRT_RATE_W = 13;

    typedef enum logic [1:0] {
        BRT_MODE_TIMER   = 2'b00,
        BRT_MODE_COUNTER = 2'b01,
        BRT_MODE_TIMEOUT = 2'b10
    } brt_mode_e;

    // Timing strobes handed to the four receiver/transmitter engines
    typedef struct packed {
        logic [3:0] clk16;
        logic [3:0] bit_tick;
        logic [3:0] mid_tick;
    } brt_clk_s;

    // Oscillator ticks per 16X period for a 3.6864 MHz reference, exact except codes 03, 04, 0D and 11
    function automatic logic [12:0] brt_rate_div(logic [5:0] code,
                                                 logic ext);
        logic [12:0] d;
        d = 13'h0000;
        unique case (code)
            6'h00: d = 13'h1200;
            6'h01: d = 13'h0C00;
            6'h02: d = 13'h0900;
            6'h03: d = 13'h082F;
            6'h04: d = 13'h06B1;
            6'h05: d = 13'h0600;
            6'h06: d = 13'h0480;
            6'h07: d = 13'h0300;
            6'h08: d = 13'h0240;
            6'h09: d = 13'h0200;
            6'h0A: d = 13'h0180;
            6'h0B: d = 13'h0120;
            6'h0C: d = 13'h0100;
            6'h0D: d = 13'h00DB;
            6'h0E: d = 13'h00C0;
            6'h0F: d = 13'h0090;
            6'h10: d = 13'h0080;
            6'h11: d = 13'h0073;
            6'h12: d = 13'h0060;
            6'h13: d = 13'h0040;
            6'h14: d = 13'h0030;
            6'h15: d = 13'h0020;
            6'h16: d = 13'h0018;
            6'h17: d = 13'h0010;
            6'h18: d = 13'h000C;
            6'h19: d = 13'h0008;
            6'h1A: d = 13'h0006;
            6'h1B: d = ext ? 13'h0004 : 13'h0000;
            6'h1C: d = ext ? 13'h0003 : 13'h0000;
            6'h1D: d = ext ? 13'h0002 : 13'h0000;
            6'h1E: d = ext ? 13'h0001 : 13'h0000;
            default: d = 13'h0000;
        endcase
        return d;
    endfunction

endpackage

// file: test/brt_engine_model.sv
// Engine-side model: measures 16X spacing and sends character strobes
`timescale 1ns/1ns
module brt_engine_model
(
    input  wire logic              pclk,
    input  wire logic              presetn,
    input  wire brt_pkg::brt_clk_s chan_clk,
    input  wire logic              chatter,
    output logic                   rx_char_strobe,
    output int                     gap [4],
    output int                     nclk [4]
);
    import brt_pkg::*;
    int age [4];
    int rx_cnt;
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            rx_cnt         <= 0;
            rx_char_strobe <= 1'b0;
            for (int i = 0; i < 4; i++)
            begin
                age[i]  <= 0;
                gap[i]  <= 0;
                nclk[i] <= 0;
            end
        end
        else
        begin
            // Received character every 8 cycles while chatter is up
            rx_cnt         <= rx_cnt + 1;
            rx_char_strobe <= chatter && (rx_cnt % 8 == 7);
            for (int i = 0; i < 4; i++)
            begin
                age[i] <= age[i] + 1;
                if (chan_clk.clk16[i])
                begin
                    gap[i]  <= age[i] + 1;
                    age[i]  <= 0;
                    nclk[i] <= nclk[i] + 1;
                end
            end
        end
    end
endmodule

// file: test/brt_timing_props.sv
// Port-level checker for the rate generator and divider block
`timescale 1ns/1ns
module brt_timing_props
#(
    parameter int DIV_WIDTH = 16
)
(
    input wire logic              pclk,
    input wire logic              presetn,
    input wire logic              psel,
    input wire logic              penable,
    input wire logic              pwrite,
    input wire logic [7:0]        paddr,
    input wire logic [31:0]       pwdata,
    input wire logic [31:0]       prdata,
    input wire logic              pready,
    input wire logic              pslverr,
    input wire logic              oscillator_input,
    input wire logic              input_port_bit_two,
    input wire logic [3:0]        ext_timing_in,
    input wire logic              rx_char_strobe,
    input wire brt_pkg::brt_clk_s chan_clk,
    input wire logic              divider_pin,
    input wire logic              irq
);
    import brt_pkg::*;
    wire acc = psel && penable;
    wire rd_acc = acc && !pwrite;
    wire mapped = (paddr <= BRT_OFS_IMR) && (paddr[1:0] == 2'b00);
    wire stop_wr = acc && pwrite && (paddr == BRT_OFS_CMD) && pwdata[1];
    logic [3:0] c16_q;
    logic [3:0] c16_d;
    // Clock-16 count since the last bit tick of selector 0
    assign c16_d = chan_clk.bit_tick[0] ? 4'h0 : c16_q + 4'h1;
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            c16_q <= 4'h0;
        else if (chan_clk.clk16[0])
            c16_q <= c16_d;
    end
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    a_ready_high: assert property (acc |-> pready)
        else $error("ready low in access");
    a_err_unmapped: assert property (acc |-> pslverr == !mapped)
        else $error("error flag wrong for address");
    a_unmapped_zero: assert property (rd_acc && !mapped |-> prdata == 32'h0)
        else $error("unmapped read not zero");
    a_cmd_reads_zero: assert property (
        rd_acc && paddr == BRT_OFS_CMD |-> prdata == 32'h0)
        else $error("command read not zero");
    a_stop_drops_irq: assert property (stop_wr |=> !irq)
        else $error("interrupt stays after stop");
    a_clk16_single: assert property (
        (chan_clk.clk16 & $past(chan_clk.clk16)) == 4'h0)
        else $error("clock pulse longer than one cycle");
    a_bit_every16: assert property (chan_clk.bit_tick[0] |->
        chan_clk.clk16[0] && c16_q == 4'hF)
        else $error("bit tick not on sixteenth pulse");
    a_mid_at8: assert property (chan_clk.mid_tick[0] |->
        chan_clk.clk16[0] && c16_q == 4'h7)
        else $error("mid tick not on eighth pulse");
    cover property (acc && pslverr);
    cover property (irq ##1 !irq);
    cover property (chan_clk.bit_tick[0]);
endmodule

// file: test/baud_rate_and_counter_timer_tb.sv
// Self-checking bench for the rate generator and divider block
`timescale 1ns/1ns
module baud_rate_and_counter_timer_tb;
    import brt_pkg::*;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rd;
    logic        osc, ip2, chatter, rx_stb, pin, irq, seen;
    logic [3:0]  ext_in;
    brt_clk_s    cc;
    int          gap [4];
    int          nclk [4];
    int          error_cnt, samples_checked, n, s, c, k, sel, tk;
    int          baud [12] = '{3600, 4800, 7200, 9600, 14400, 19200,
                               28800, 38400, 57600, 76800, 115200, 230400};
    brt_timing #(.DIV_WIDTH(16)) DUT (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .oscillator_input(osc),
        .input_port_bit_two(ip2), .ext_timing_in(ext_in),
        .rx_char_strobe(rx_stb), .chan_clk(cc), .divider_pin(pin),
        .irq(irq));
    brt_engine_model u_eng (.pclk(pclk), .presetn(presetn), .chan_clk(cc),
        .chatter(chatter), .rx_char_strobe(rx_stb), .gap(gap), .nclk(nclk));
    task automatic close_out();
        if (error_cnt == 0 && samples_checked > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd      = prdata;
        seen    = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic settle(input int i);
        c = nclk[i];
        for (k = 0; nclk[i] < c + 3 && k < 4000; k++)
            @(posedge pclk);
    endtask
    task automatic wait_irq();
        for (k = 0; irq !== 1'b1 && k < 2000; k++)
            @(posedge pclk);
    endtask
    function automatic logic [31:0] lanes(input int i, input logic [5:0] v);
        logic [31:0] r;
        r = 32'h3F3F_3F3F;
        r[8*i +: 6] = v;
        return r;
    endfunction
    initial
    begin
        pclk = 1'b0;
        forever #4 pclk = ~pclk;
    end
    // Reference 4 cycles, divider input 6, external 16X 10
    always @(posedge pclk)
    begin
        osc    <= (tk % 4) < 2;
        ip2    <= (tk % 6) < 3;
        ext_in <= {4{(tk % 10) < 5}};
        tk     <= tk + 1;
    end
    initial
    begin
        repeat (80000) @(posedge pclk);
        error_cnt++;
        close_out();
    end
    initial
    begin
        {psel, penable, pwrite, chatter, osc, ip2, presetn} = 7'h00;
        {paddr, pwdata, ext_in, tk, error_cnt, samples_checked} = 0;
        c = $urandom(62871);
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        apb(0, BRT_OFS_PRE_LO, 0);
        chk(rd, 32'h0000_0002);
        apb(0, BRT_OFS_CLKSEL, 0);
        chk(rd, 32'h0000_0000);
        apb(0, 8'h24, 0);
        chk({rd[30:0], seen}, 32'h0000_0001);
        apb(1, BRT_OFS_CTRL, 32'h0000_0001);
        for (s = 0; s < 7; s++)
        begin
            n   = (s == 0) ? 11 : $urandom % 12;
            sel = $urandom % 4;
            apb(1, BRT_OFS_CLKSEL, lanes(sel, 6'h13 + n[5:0]));
            settle(sel);
            chk(gap[sel], 4 * 230400 / baud[n]);
        end
        // Fastest extended rate on selector 0, long enough for bit ticks
        apb(1, BRT_OFS_CLKSEL, lanes(0, 6'h1E));
        repeat (140) @(posedge pclk);
        chk(gap[0], 4 * 230400 / baud[11]);
        apb(1, BRT_OFS_CTRL, 32'h0000_0000);
        repeat (8) @(posedge pclk);
        c = nclk[0];
        repeat (200) @(posedge pclk);
        chk(nclk[0], c);
        apb(1, BRT_OFS_CLKSEL, lanes(3, BRT_SEL_EXTERN));
        settle(3);
        chk(gap[3], 10);
        n = 2 + $urandom % 8;
        apb(1, BRT_OFS_PRE_HI, 32'h0000_005A);
        apb(0, BRT_OFS_PRE_HI, 0);
        chk(rd, 32'h0000_005A);
        apb(1, BRT_OFS_PRE_HI, 0);
        apb(1, BRT_OFS_PRE_LO, n);
        apb(1, BRT_OFS_IMR, 32'h0000_0001);
        apb(1, BRT_OFS_CTRL, 32'h0000_0010);
        apb(1, BRT_OFS_CLKSEL, lanes(2, BRT_SEL_DIVIDER));
        apb(1, BRT_OFS_CMD, 32'h0000_0001);
        settle(2);
        chk(gap[2], 8 * n);
        chk(irq, 1'b1);
        s = 0;
        repeat (8 * n) @(posedge pclk) s += pin;
        chk(s > 0 && s < 8 * n, 1'b1);
        apb(1, BRT_OFS_IMR, 0);
        apb(1, BRT_OFS_CMD, 32'h0000_0003);
        // Terminal count in the first stop's cycle may still set a bit
        apb(1, BRT_OFS_CMD, 32'h0000_0002);
        apb(0, BRT_OFS_STATUS, 0);
        chk(rd[BRT_STAT_RUN_BIT], 1'b0);
        apb(0, BRT_OFS_ISR, 0);
        chk(rd[1:0], 2'b00);
        apb(1, BRT_OFS_CTRL, 32'h0000_0008);
        apb(1, BRT_OFS_CMD, 32'h0000_0001);
        settle(2);
        chk(gap[2], 12 * n);
        apb(1, BRT_OFS_CMD, 32'h0000_0002);
        apb(1, BRT_OFS_IMR, 32'h0000_0001);
        apb(1, BRT_OFS_CTRL, 32'h0000_0002);
        apb(1, BRT_OFS_CMD, 32'h0000_0001);
        wait_irq();
        chk(k >= 4 * n - 4 && k <= 4 * n + 6, 1'b1);
        apb(0, BRT_OFS_STATUS, 0);
        chk(rd[BRT_STAT_RUN_BIT], 1'b0);
        apb(1, BRT_OFS_CMD, 32'h0000_0002);
        @(posedge pclk);
        chk(irq, 1'b0);
        n = 5;
        apb(1, BRT_OFS_PRE_LO, n);
        apb(1, BRT_OFS_IMR, 32'h0000_0002);
        apb(1, BRT_OFS_CTRL, 32'h0000_0004);
        chatter <= 1'b1;
        apb(1, BRT_OFS_CMD, 32'h0000_0001);
        repeat (20 * n) @(posedge pclk);
        chk(irq, 1'b0);
        chatter <= 1'b0;
        wait_irq();
        chk(irq, 1'b1);
        apb(1, BRT_OFS_ISR, 32'h0000_0002);
        @(posedge pclk);
        chk(irq, 1'b0);
        close_out();
    end
endmodule
bind brt_timing brt_timing_props #(.DIV_WIDTH(DIV_WIDTH)) u_props (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .oscillator_input(oscillator_input),
    .input_port_bit_two(input_port_bit_two), .ext_timing_in(ext_timing_in),
    .rx_char_strobe(rx_char_strobe), .chan_clk(chan_clk),
    .divider_pin(divider_pin), .irq(irq));
